// >>> rtl/prsc_regs.svh
// Register indices, field positions, reset values and timing counts of the sleep controller
//
// Behaviour
// RL1 - Reset pulse is issued in the configuration step after reset and every reconfiguration.
// RL2 - Pin-select field 2:1 picks none, serial data, SPI MOSI or digital audio pin.
// RL3 - Bit 0 sets pulse polarity: 0 active low, 1 active high.
// RL4 - Pulse stays asserted about 285 us, then the pin returns inactive.
// RL5 - Software keeps reset-output settings in configuration memory before reconfiguring.
// RL6 - Controller sets receiver power-down bit before the transmitter power-down bit.
// RL7 - Power down is refused while the wake-interval register holds zero.
// RL8 - Writing 0x01 starts the transfer; receiver powers down when it completes.
// RL9 - Lost link with nonzero wake interval starts a timeout towards automatic power down.
// RL10 - Timeout is the 16-bit sleep interval times 10 ms.
// RL11 - Power down ends on an enabled wake-pin change or sleep-timer expiry.
// RL12 - Controller clears both power-down bits to stop power-down operation.
// RL13 - Transmitter role wakes on its wake pin only with mode bit 5 set.
// RL14 - Receiver role wakes on any enabled digital input pin change, bits 3:0.
// RL15 - Receiver sleep-timer wake bit 4 wins; pin wake only while it is clear.
// RL16 - After waking, return to power down unless the power-down bit is cleared.
// RL17 - Pin-wake window is wake interval times extension plus one times 10 ms.
// RL18 - Input pulses of at least 1 ms are recognised as wake events.
// RL19 - Transmitter with zero wake interval never returns to power down on timers.
// RL20 - Wake pins are synchronised and changes found by comparing successive samples.
`ifndef PRSC_REGS_SVH
`define PRSC_REGS_SVH

// Word indices; byte address is four times the index
`define PRSC_IDX_RX_RESO 8'h40
`define PRSC_IDX_RX_WAKE 8'h45
`define PRSC_IDX_RX_STI0 8'h46
`define PRSC_IDX_RX_STI1 8'h47
`define PRSC_IDX_RX_WTI 8'h48
`define PRSC_IDX_RX_LTI 8'h4c
`define PRSC_IDX_TX_LTI 8'h4d
`define PRSC_IDX_TX_RESO 8'h50
`define PRSC_IDX_TX_STI0 8'h57
`define PRSC_IDX_TX_STI1 8'h58
`define PRSC_IDX_TX_WTI 8'h59
`define PRSC_IDX_TX_MODE 8'h60
`define PRSC_IDX_RX_MODE 8'h61
`define PRSC_IDX_RX_XFER 8'h62
`define PRSC_IDX_RECONF 8'h63
`define PRSC_IDX_STATUS 8'h64

// Field positions
`define PRSC_RESO_POL 0
`define PRSC_WAKE_TIMER 4
`define PRSC_TXMODE_PD 6
`define PRSC_TXMODE_PINWAKE 5
`define PRSC_RXMODE_PD 7
`define PRSC_XFER_START 8'h01

// Reset value of every writable register
`define PRSC_REG_RESET 8'h00

// Timing
`define PRSC_CLK_KHZ 100000
`define PRSC_TICK_MS 10
`define PRSC_WAKE_MIN_MS 1
`define PRSC_PULSE_US 285
`define PRSC_TICK_CYC (`PRSC_TICK_MS * `PRSC_CLK_KHZ)
`define PRSC_WAKE_MIN_CYC (`PRSC_WAKE_MIN_MS * `PRSC_CLK_KHZ)
`define PRSC_PULSE_CYC ((`PRSC_PULSE_US * `PRSC_CLK_KHZ + 999) / 1000)

`endif

// >>> rtl/prsc_pkg.sv
// Types shared by the sleep controller
package prsc_pkg;
  typedef enum logic [2:0] {
    ST_CFG,
    ST_ACTIVE,
    ST_LOST,
    ST_SLEEP,
    ST_WAKE
  } prsc_state_type;
endpackage

// >>> rtl/prsc_tick_div.sv
// Divider producing a one-cycle timer tick enable
`timescale 1ns/1ns
module prsc_tick_div #(
  parameter int unsigned DIV = 1000000
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Restart the period
  input wire logic clr_i,
  // Tick
  output logic tick_o
);
  localparam int unsigned CW = $clog2(DIV);

  logic [CW-1:0] cnt_ff;

  if (DIV < 2) begin : g_bad_div
    $error("prsc_tick_div: DIV must be at least 2");
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || clr_i) begin
      cnt_ff <= '0;
      tick_o <= 1'b0;
    end else if (cnt_ff == CW'(DIV - 1)) begin
      cnt_ff <= '0;
      tick_o <= 1'b1;
    end else begin
      cnt_ff <= cnt_ff + CW'(1);
      tick_o <= 1'b0;
    end
  end
endmodule // prsc_tick_div

// >>> rtl/prsc_pin_filter.sv
// Three-stage synchroniser and minimum-width filter for wake pins
`timescale 1ns/1ns
module prsc_pin_filter #(
  parameter int unsigned WIDTH = 5,
  parameter int unsigned MIN_CYC = 100000
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Pins and filtered levels
  input wire logic [WIDTH-1:0] pins_i,
  output logic [WIDTH-1:0] level_o
);
  localparam int unsigned CW = $clog2(MIN_CYC);

  if (MIN_CYC < 2 || WIDTH < 1) begin : g_bad_par
    $error("prsc_pin_filter: MIN_CYC must be at least 2");
  end

  for (genvar g = 0; g < WIDTH; g++) begin : g_pin
    logic [2:0] sync_ff;
    logic [CW-1:0] cnt_ff;

    // Only stage 1 reads stage 0
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        sync_ff <= 3'h0;
      end else begin
        sync_ff <= {sync_ff[1:0], pins_i[g]}; // [RL20]
      end
    end

    // A new level must stand MIN_CYC cycles before it counts, so glitches never wake
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        cnt_ff <= '0;
        level_o[g] <= 1'b0;
      end else if (sync_ff[1] == sync_ff[2] && sync_ff[2] != level_o[g]) begin
        if (cnt_ff == CW'(MIN_CYC - 1)) begin
          cnt_ff <= '0;
          level_o[g] <= sync_ff[2]; // [RL18]
        end else begin
          cnt_ff <= cnt_ff + CW'(1);
        end
      end else begin
        cnt_ff <= '0;
      end
    end
  end
endmodule // prsc_pin_filter

// >>> rtl/prsc_top.sv
// Peripheral reset pulse and power-down sequencing with Wishbone registers
`timescale 1ns/1ns
`include "prsc_regs.svh"
module prsc_top #(
  parameter int unsigned TICK_CYC = `PRSC_TICK_CYC,
  parameter int unsigned WAKE_MIN_CYC = `PRSC_WAKE_MIN_CYC,
  parameter int unsigned PULSE_CYC = `PRSC_PULSE_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] sel_i,
  input wire logic [9:0] adr_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Role and radio link
  input wire logic receiver_role_i,
  input wire logic link_up_i,
  input wire logic remote_xfer_done_i,
  output logic remote_xfer_start_o,
  // Wake pins
  input wire logic transmitter_wake_pin_i,
  input wire logic [3:0] digital_input_pins_i,
  // Reset pulse pins: 0 serial data, 1 SPI MOSI, 2 digital audio
  output logic [2:0] rst_pin_o,
  output logic [2:0] rst_pin_oe_o,
  // Power state
  output logic power_down_o
);
  localparam int unsigned PW = $clog2(PULSE_CYC);

  if (PULSE_CYC < 2 || PULSE_CYC > 65535) begin : g_bad_pulse
    $error("prsc_top: PULSE_CYC out of range");
  end

  prsc_pkg::prsc_state_type state_ff;
  prsc_pkg::prsc_state_type nxt_state;
  logic [15:0] cnt_ff;
  logic [15:0] nxt_cnt;
  logic [PW-1:0] pulse_cnt_ff;
  logic role_ff;
  logic reconf_ff;
  logic xfer_pend_ff;
  logic xfer_done_ff;
  logic [4:0] prev_ff;
  logic [4:0] level;
  logic [4:0] chg;
  logic tick;
  logic expire;
  logic pin_hit;
  logic pd_bit;
  logic pd_req;
  logic timer_wake;
  logic [2:0] cur_reso;
  logic [7:0] cur_wti;
  logic [7:0] cur_lti;
  logic [15:0] cur_sti;
  logic [24:0] ext_prod;
  logic [15:0] ext_win;
  logic in_cfg;
  logic req;
  logic wr;
  logic [7:0] idx;
  logic [7:0] rd_byte;

  // Registers
  logic [2:0] transmitter_reset_output_cfg_ff;
  logic [2:0] receiver_reset_output_cfg_ff;
  logic [4:0] receiver_wake_sources_ff;
  logic [7:0] txmode_ff;
  logic [7:0] rxmode_ff;
  logic [15:0] transmitter_sleep_interval_ff;
  logic [15:0] receiver_sleep_interval_ff;
  logic [7:0] transmitter_wake_interval_ff;
  logic [7:0] receiver_wake_interval_ff;
  logic [7:0] transmitter_wake_extension_ff;
  logic [7:0] receiver_wake_extension_ff;

  assign req = cyc_i && stb_i && !ack_o;
  assign wr = req && we_i && sel_i[0];
  assign idx = adr_i[9:2];
  assign in_cfg = (state_ff == prsc_pkg::ST_CFG);

  // Bus answer: one ack per request, one cycle after it is seen
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0;
    end else begin
      ack_o <= req;
      if (req && !we_i) begin
        dat_o <= {24'h0, rd_byte};
      end
    end
  end

  always_comb begin
    rd_byte = 8'h00;
    case (idx)
      `PRSC_IDX_RX_RESO: rd_byte = {5'h00, receiver_reset_output_cfg_ff};
      `PRSC_IDX_TX_RESO: rd_byte = {5'h00, transmitter_reset_output_cfg_ff};
      `PRSC_IDX_RX_WAKE: rd_byte = {3'h0, receiver_wake_sources_ff};
      `PRSC_IDX_TX_MODE: rd_byte = txmode_ff;
      `PRSC_IDX_RX_MODE: rd_byte = rxmode_ff;
      `PRSC_IDX_TX_STI0: rd_byte = transmitter_sleep_interval_ff[7:0];
      `PRSC_IDX_TX_STI1: rd_byte = transmitter_sleep_interval_ff[15:8];
      `PRSC_IDX_RX_STI0: rd_byte = receiver_sleep_interval_ff[7:0];
      `PRSC_IDX_RX_STI1: rd_byte = receiver_sleep_interval_ff[15:8];
      `PRSC_IDX_TX_WTI: rd_byte = transmitter_wake_interval_ff;
      `PRSC_IDX_RX_WTI: rd_byte = receiver_wake_interval_ff;
      `PRSC_IDX_TX_LTI: rd_byte = transmitter_wake_extension_ff;
      `PRSC_IDX_RX_LTI: rd_byte = receiver_wake_extension_ff;
      `PRSC_IDX_STATUS: rd_byte = {2'h0, xfer_done_ff, link_up_i, role_ff, state_ff};
      default: rd_byte = 8'h00;
    endcase
  end

  // Reserved bits above the reset-output and wake-source fields are not stored, so they read as zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      // Settings are lost on reset; software restores them before reconfiguring [RL5]
      transmitter_reset_output_cfg_ff <= 3'(`PRSC_REG_RESET);
      receiver_reset_output_cfg_ff <= 3'(`PRSC_REG_RESET);
      receiver_wake_sources_ff <= 5'(`PRSC_REG_RESET);
      txmode_ff <= `PRSC_REG_RESET;
      rxmode_ff <= `PRSC_REG_RESET;
      transmitter_sleep_interval_ff <= {`PRSC_REG_RESET, `PRSC_REG_RESET};
      receiver_sleep_interval_ff <= {`PRSC_REG_RESET, `PRSC_REG_RESET};
      transmitter_wake_interval_ff <= `PRSC_REG_RESET;
      receiver_wake_interval_ff <= `PRSC_REG_RESET;
      transmitter_wake_extension_ff <= `PRSC_REG_RESET;
      receiver_wake_extension_ff <= `PRSC_REG_RESET;
    end else if (wr) begin
      case (idx)
        `PRSC_IDX_RX_RESO: receiver_reset_output_cfg_ff <= dat_i[2:0];
        `PRSC_IDX_TX_RESO: transmitter_reset_output_cfg_ff <= dat_i[2:0];
        `PRSC_IDX_RX_WAKE: receiver_wake_sources_ff <= dat_i[4:0];
        `PRSC_IDX_TX_MODE: txmode_ff <= dat_i[7:0];
        `PRSC_IDX_RX_MODE: rxmode_ff <= dat_i[7:0];
        `PRSC_IDX_TX_STI0: transmitter_sleep_interval_ff[7:0] <= dat_i[7:0];
        `PRSC_IDX_TX_STI1: transmitter_sleep_interval_ff[15:8] <= dat_i[7:0];
        `PRSC_IDX_RX_STI0: receiver_sleep_interval_ff[7:0] <= dat_i[7:0];
        `PRSC_IDX_RX_STI1: receiver_sleep_interval_ff[15:8] <= dat_i[7:0];
        `PRSC_IDX_TX_WTI: transmitter_wake_interval_ff <= dat_i[7:0];
        `PRSC_IDX_RX_WTI: receiver_wake_interval_ff <= dat_i[7:0];
        `PRSC_IDX_TX_LTI: transmitter_wake_extension_ff <= dat_i[7:0];
        `PRSC_IDX_RX_LTI: receiver_wake_extension_ff <= dat_i[7:0];
        default: ;
      endcase
    end
  end

  // Command strobes and transfer tracking; a completion beats the clear on sleep entry
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      reconf_ff <= 1'b0;
      remote_xfer_start_o <= 1'b0;
      xfer_pend_ff <= 1'b0;
      xfer_done_ff <= 1'b0;
    end else begin
      reconf_ff <= wr && idx == `PRSC_IDX_RECONF && dat_i[0];
      remote_xfer_start_o <= wr && idx == `PRSC_IDX_RX_XFER && dat_i[7:0] == `PRSC_XFER_START;
      if (wr && idx == `PRSC_IDX_RX_XFER && dat_i[7:0] == `PRSC_XFER_START) begin
        xfer_pend_ff <= 1'b1; // [RL8]
      end else if (remote_xfer_done_i) begin
        xfer_pend_ff <= 1'b0;
      end
      if (remote_xfer_done_i && xfer_pend_ff) begin
        xfer_done_ff <= 1'b1; // [RL8]
      end else if (state_ff == prsc_pkg::ST_SLEEP) begin
        xfer_done_ff <= 1'b0;
      end
    end
  end

  // Role is taken while configuring, so a role change needs a reconfiguration
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      role_ff <= 1'b0;
    end else if (in_cfg) begin
      role_ff <= receiver_role_i;
    end
  end

  assign cur_reso = role_ff ? receiver_reset_output_cfg_ff : transmitter_reset_output_cfg_ff;
  assign cur_wti = role_ff ? receiver_wake_interval_ff : transmitter_wake_interval_ff;
  assign cur_lti = role_ff ? receiver_wake_extension_ff : transmitter_wake_extension_ff;
  assign cur_sti = role_ff ? receiver_sleep_interval_ff : transmitter_sleep_interval_ff;
  // Controller orders the two bits across the pair; each role sees only its own [RL6]
  assign pd_bit = role_ff ? rxmode_ff[`PRSC_RXMODE_PD] : txmode_ff[`PRSC_TXMODE_PD];
  assign pd_req = pd_bit && (!role_ff || xfer_done_ff); // [RL8]
  assign timer_wake = role_ff ? receiver_wake_sources_ff[`PRSC_WAKE_TIMER] : 1'b1;
  assign ext_prod = 25'(cur_wti) * (25'(cur_lti) + 25'h1);
  assign ext_win = ext_prod[15:0]; // [RL17]
  assign expire = tick && cnt_ff <= 16'h0001;

  // Reset pulse timing
  always_ff @(posedge clk_i) begin
    if (rst_i || !in_cfg || reconf_ff) begin
      pulse_cnt_ff <= '0;
    end else if (pulse_cnt_ff != PW'(PULSE_CYC - 1)) begin
      pulse_cnt_ff <= pulse_cnt_ff + PW'(1); // [RL4]
    end
  end

  // Selected pin is driven active for the whole configuration step, inactive after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rst_pin_o <= 3'h0;
      rst_pin_oe_o <= 3'h0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        rst_pin_oe_o[i] <= (cur_reso[2:1] == 2'(i + 1)); // [RL2]
        rst_pin_o[i] <= in_cfg ? cur_reso[`PRSC_RESO_POL] : !cur_reso[`PRSC_RESO_POL]; // [RL3]
      end
    end
  end

  prsc_pin_filter #(
    .WIDTH(5),
    .MIN_CYC(WAKE_MIN_CYC)
  ) u_filter (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pins_i({transmitter_wake_pin_i, digital_input_pins_i}),
    .level_o(level)
  );

  // Divider restarts on each state change so the first period is a full 10 ms
  prsc_tick_div #(
    .DIV(TICK_CYC)
  ) u_tick (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clr_i(nxt_state != state_ff),
    .tick_o(tick)
  );

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev_ff <= 5'h00;
    end else begin
      prev_ff <= level;
    end
  end

  assign chg = level ^ prev_ff; // [RL20]
  assign pin_hit = role_ff ?
      (!receiver_wake_sources_ff[`PRSC_WAKE_TIMER] && |(chg[3:0] & receiver_wake_sources_ff[3:0])) : // [RL14] [RL15]
      (txmode_ff[`PRSC_TXMODE_PINWAKE] && chg[4]); // [RL13]

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = (tick && cnt_ff != 16'h0000) ? cnt_ff - 16'h0001 : cnt_ff;
    case (state_ff)
      prsc_pkg::ST_CFG: begin
        if (pulse_cnt_ff == PW'(PULSE_CYC - 1)) begin
          nxt_state = prsc_pkg::ST_ACTIVE;
        end
      end
      prsc_pkg::ST_ACTIVE: begin
        if (cur_wti != 8'h00) begin // [RL7]
          if (pd_req) begin
            nxt_state = prsc_pkg::ST_SLEEP;
            nxt_cnt = cur_sti;
          end else if (!link_up_i) begin
            nxt_state = prsc_pkg::ST_LOST; // [RL9]
            nxt_cnt = cur_sti; // [RL10]
          end
        end
      end
      prsc_pkg::ST_LOST: begin
        if (link_up_i || cur_wti == 8'h00) begin // [RL9]
          nxt_state = prsc_pkg::ST_ACTIVE;
        end else if (pd_req || expire) begin
          nxt_state = prsc_pkg::ST_SLEEP;
          nxt_cnt = cur_sti;
        end
      end
      prsc_pkg::ST_SLEEP: begin
        if (pin_hit) begin
          nxt_state = prsc_pkg::ST_WAKE; // [RL11]
          nxt_cnt = ext_win; // [RL17]
        end else if (timer_wake && expire) begin
          nxt_state = prsc_pkg::ST_WAKE; // [RL11] [RL15]
          nxt_cnt = {8'h00, cur_wti};
        end
      end
      prsc_pkg::ST_WAKE: begin
        if (!pd_bit) begin
          nxt_state = prsc_pkg::ST_ACTIVE; // [RL12]
        end else if (cur_wti != 8'h00 && expire) begin // [RL19]
          nxt_state = prsc_pkg::ST_SLEEP; // [RL16]
          nxt_cnt = cur_sti;
        end
      end
      default: nxt_state = prsc_pkg::ST_CFG;
    endcase
    if (reconf_ff) begin
      nxt_state = prsc_pkg::ST_CFG; // [RL1]
    end
  end

  // Reset lands in the configuration step, which issues the pulse
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= prsc_pkg::ST_CFG; // [RL1]
      cnt_ff <= 16'h0000;
      power_down_o <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      power_down_o <= (nxt_state == prsc_pkg::ST_SLEEP);
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_ack_single: assert property (ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");
  a_ack_timely: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("request not answered in one cycle");
  a_cfg_after_reset: assert property ($fell(rst_i) |-> in_cfg ##1 in_cfg) // [RL1]
    else $error("no configuration step after reset");
  a_reconf_restart: assert property (reconf_ff |=> in_cfg && pulse_cnt_ff == '0) // [RL1]
    else $error("reconfiguration did not restart the pulse");
  a_pulse_length: assert property ($fell(in_cfg) |-> $past(pulse_cnt_ff) == PW'(PULSE_CYC - 1)) // [RL4]
    else $error("reset pulse length wrong");
  a_pin_none: assert property (cur_reso[2:1] == 2'h0 |=> rst_pin_oe_o == 3'h0) // [RL2]
    else $error("pin driven with selection zero");
  a_pulse_level: assert property (in_cfg && cur_reso == 3'h3 |=> rst_pin_oe_o == 3'h1
      && rst_pin_o[0]) // [RL3]
    else $error("active-high pulse not on serial data pin");
  a_sleep_wti: assert property (nxt_state == prsc_pkg::ST_SLEEP && state_ff != prsc_pkg::ST_SLEEP
      |-> cur_wti != 8'h00) // [RL7]
    else $error("power down with zero wake interval");
  a_lost_start: assert property (state_ff == prsc_pkg::ST_ACTIVE && !link_up_i && cur_wti != 8'h00
      && !pd_req && !reconf_ff |=> state_ff == prsc_pkg::ST_LOST && cnt_ff == $past(cur_sti)) // [RL9]
    else $error("lost link did not start timeout");
  a_timer_prio: assert property (state_ff == prsc_pkg::ST_SLEEP && role_ff
      && receiver_wake_sources_ff[`PRSC_WAKE_TIMER] && !expire && !reconf_ff |=> state_ff == prsc_pkg::ST_SLEEP) // [RL15]
    else $error("pin woke receiver while timer wake set");
  a_pin_wake: assert property (state_ff == prsc_pkg::ST_SLEEP && pin_hit && !reconf_ff
      |=> state_ff == prsc_pkg::ST_WAKE && cnt_ff == $past(ext_win)) // [RL17]
    else $error("pin wake window wrong");
  a_tx_no_return: assert property (state_ff == prsc_pkg::ST_WAKE && !role_ff && transmitter_wake_interval_ff == 8'h00
      |=> state_ff != prsc_pkg::ST_SLEEP) // [RL19]
    else $error("transmitter slept with zero wake interval");

  c_sleep_wake: cover property (state_ff == prsc_pkg::ST_SLEEP ##1 state_ff == prsc_pkg::ST_WAKE);
  c_lost_sleep: cover property (state_ff == prsc_pkg::ST_LOST ##1 state_ff == prsc_pkg::ST_SLEEP);
  c_pulse_done: cover property ($fell(in_cfg) && cur_reso[2:1] != 2'h0);
  c_wake_active: cover property (state_ff == prsc_pkg::ST_WAKE ##1 state_ff == prsc_pkg::ST_ACTIVE);
endmodule // prsc_top

// >>> testbench/prsc_link_partner.sv
// Far-side radio model: link presence and remote settings transfer completion
`timescale 1ns/1ns
module prsc_link_partner (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Bench controls
  input wire logic link_en_i,
  input wire logic [7:0] reply_delay_i,
  // Device side
  input wire logic xfer_start_i,
  output logic link_up_o,
  output logic xfer_done_o
);
  logic link_ff;
  logic busy_ff;
  logic done_ff;
  logic [7:0] cnt_ff;

  // Link follows the bench control one cycle late, like a radio losing sync
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      link_ff <= 1'b0;
    end else begin
      link_ff <= link_en_i;
    end
  end

  // Transfer completes after a programmable delay, zero gives a prompt reply
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
      cnt_ff <= 8'h00;
    end else begin
      done_ff <= 1'b0;
      if (xfer_start_i && !busy_ff) begin
        busy_ff <= 1'b1;
        cnt_ff <= reply_delay_i;
      end else if (busy_ff && cnt_ff == 8'h00) begin
        busy_ff <= 1'b0;
        done_ff <= 1'b1;
      end else if (busy_ff) begin
        cnt_ff <= cnt_ff - 8'h01;
      end
    end
  end

  assign link_up_o = link_ff;
  assign xfer_done_o = done_ff;
endmodule // prsc_link_partner

// >>> testbench/test_peripheral_reset_and_sleep_control.sv
// Self-checking bench for the peripheral reset and sleep controller
`timescale 1ns/1ns
module test_peripheral_reset_and_sleep_control;
  typedef struct {
    logic [7:0] idx;
    logic [7:0] d;
    logic [3:0] s;
    logic [7:0] e;
  } prsc_row_type;
  logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, role, link_up, link_en;
  logic xfer_start, xfer_done, tx_pin, power_down, pol;
  logic [3:0] sel_i, dpins;
  logic [9:0] adr_i;
  logic [31:0] dat_i, dat_o, q;
  logic [2:0] pin, pin_oe;
  logic [7:0] delay, v;
  int errors = 0;
  int comparisons = 0;
  int starts = 0;
  int n;
  // Rows with sel 0 write nothing, so they read back the reset value
  prsc_row_type rows [11] = '{
    '{8'h40, 8'hff, 4'h0, 8'h00}, '{8'h45, 8'hff, 4'h0, 8'h00},
    '{8'h50, 8'hff, 4'h0, 8'h00}, '{8'h46, 8'hff, 4'h0, 8'h00},
    '{8'h40, 8'hff, 4'h1, 8'h07}, '{8'h45, 8'hff, 4'h1, 8'h1f},
    '{8'h50, 8'hff, 4'hf, 8'h07}, '{8'h46, 8'ha5, 4'h1, 8'ha5},
    '{8'h46, 8'h5a, 4'he, 8'ha5}, '{8'h7f, 8'h3c, 4'h1, 8'h00},
    '{8'h4c, 8'h81, 4'h1, 8'h81}};

  prsc_top #(.TICK_CYC(20), .WAKE_MIN_CYC(8), .PULSE_CYC(16)) DUT (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .sel_i(sel_i), .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .receiver_role_i(role), .link_up_i(link_up), .remote_xfer_done_i(xfer_done),
    .remote_xfer_start_o(xfer_start), .transmitter_wake_pin_i(tx_pin),
    .digital_input_pins_i(dpins), .rst_pin_o(pin), .rst_pin_oe_o(pin_oe),
    .power_down_o(power_down));

  prsc_link_partner partner (
    .clk_i(clk_i), .rst_i(rst_i), .link_en_i(link_en), .reply_delay_i(delay),
    .xfer_start_i(xfer_start), .link_up_o(link_up), .xfer_done_o(xfer_done));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  always @(posedge clk_i) if (xfer_start === 1'b1) starts++;

  task automatic wrap_up();
    if (errors == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rng(input int got, input int lo, input int hi);
    comparisons++;
    if (got < lo || got > hi) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h..%h", $time, got, lo, hi);
    end
  endtask

  // Request held until ack is sampled high; a dead slave is cut off by the bound
  task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d,
                    input logic [3:0] s, output logic [31:0] r);
    int c;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= {idx, 2'b00};
    dat_i <= {24'h000000, d};
    sel_i <= s;
    c = 0;
    do begin
      @(posedge clk_i);
      c++;
    end while (ack_o !== 1'b1 && c < 20);
    r = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    if (c >= 20) chk(32'(ack_o), 32'h1);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] r;
    wb(1'b1, idx, d, 4'h1, r);
  endtask

  task automatic wait_pd(input logic lvl, input int lim, output int c);
    c = 0;
    while (power_down !== lvl && c < lim) begin
      @(posedge clk_i);
      c++;
    end
  endtask

  initial begin
    #300000;
    errors++;
    wrap_up();
  end

  initial begin
    rst_i = 1'b1; cyc_i = 1'b0; stb_i = 1'b0; we_i = 1'b0; sel_i = 4'h0;
    adr_i = 10'h000; dat_i = 32'h0; role = 1'b0; tx_pin = 1'b0; dpins = 4'h0;
    link_en = 1'b1; delay = 8'h1e;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    #1;
    chk({27'h0, pin_oe, power_down, ack_o}, 32'h0);
    foreach (rows[i]) begin
      wb(1'b1, rows[i].idx, rows[i].d, rows[i].s, q);
      wb(1'b0, rows[i].idx, 8'h00, 4'h0, q);
      chk(q, {24'h0, rows[i].e});
    end
    // Second reconfiguration measures from a known inactive level
    for (int k = 1; k < 4; k++) begin
      pol = k[0];
      v = 8'(k * 2 + k % 2);
      wr(8'h50, v);
      repeat (2) begin
        wr(8'h63, 8'h01);
        n = 0;
        repeat (40) begin
          @(posedge clk_i);
          if (pin[k-1] === pol && pin_oe === 3'(1 << (k - 1))) n++;
        end
      end
      chk(n, 16);
      chk(32'(pin[k-1]), 32'(!pol));
    end
    wr(8'h50, 8'h01);
    wr(8'h63, 8'h01);
    repeat (40) @(posedge clk_i);
    chk(32'(pin_oe), 32'h0);
    wr(8'h60, 8'h40);
    repeat (60) @(posedge clk_i);
    chk(32'(power_down), 32'h0);
    wr(8'h57, 8'h03);
    wr(8'h58, 8'h00);
    wr(8'h59, 8'h02);
    wait_pd(1'b1, 5, n);
    chk(32'(power_down), 32'h1);
    wait_pd(1'b0, 100, n);
    rng(n, 59, 63);
    wait_pd(1'b1, 100, n);
    rng(n, 39, 43);
    wait_pd(1'b0, 100, n);
    wr(8'h60, 8'h00);
    repeat (100) @(posedge clk_i);
    chk(32'(power_down), 32'h0);
    wr(8'h58, 8'h01);
    wr(8'h4d, 8'h01);
    wr(8'h60, 8'h40);
    wait_pd(1'b1, 10, n);
    tx_pin <= 1'b1;
    repeat (40) @(posedge clk_i);
    chk(32'(power_down), 32'h1);
    wr(8'h60, 8'h60);
    tx_pin <= 1'b0;
    wait_pd(1'b0, 30, n);
    chk(32'(power_down), 32'h0);
    wait_pd(1'b1, 200, n);
    rng(n, 79, 83);
    tx_pin <= 1'b1;
    wait_pd(1'b0, 30, n);
    wr(8'h60, 8'h00);
    wr(8'h58, 8'h00);
    link_en <= 1'b0;
    wait_pd(1'b1, 100, n);
    rng(n, 60, 66);
    link_en <= 1'b1;
    wait_pd(1'b0, 100, n);
    role <= 1'b1;
    wr(8'h63, 8'h01);
    repeat (40) @(posedge clk_i);
    wr(8'h48, 8'h02);
    wr(8'h46, 8'h03);
    wr(8'h47, 8'h00);
    wr(8'h4c, 8'h00);
    wr(8'h45, 8'h04);
    wr(8'h61, 8'h80);
    repeat (40) @(posedge clk_i);
    chk(32'(power_down), 32'h0);
    wr(8'h62, 8'h01);
    repeat (20) @(posedge clk_i);
    chk(32'(power_down), 32'h0);
    chk(starts, 1);
    wait_pd(1'b1, 30, n);
    chk(32'(power_down), 32'h1);
    dpins <= 4'b0010;
    repeat (40) @(posedge clk_i);
    chk(32'(power_down), 32'h1);
    dpins <= 4'b0110;
    wait_pd(1'b0, 30, n);
    chk(32'(power_down), 32'h0);
    wait_pd(1'b1, 100, n);
    rng(n, 39, 43);
    wr(8'h45, 8'h14);
    dpins <= 4'b0010;
    repeat (30) @(posedge clk_i);
    chk(32'(power_down), 32'h1);
    wait_pd(1'b0, 100, n);
    chk(32'(power_down), 32'h0);
    wrap_up();
  end
endmodule // test_peripheral_reset_and_sleep_control
